// ==== logic/low_voltage_detect_consts.vh ====
`ifndef LOW_VOLTAGE_DETECT_CONSTS_VH
`define LOW_VOLTAGE_DETECT_CONSTS_VH

// Register byte offsets on the APB.
`define OFS_CONTROL 8'h00
`define OFS_LEVEL 8'h04
`define OFS_IRQ 8'h08
`define OFS_RESET_SOURCE 8'h0c
`define OFS_OPTION 8'h10

// Control register fields.
`define BIT_ENABLE 7
`define BIT_SOURCE 2
`define BIT_MODE 1
`define BIT_LEVEL_FLAG 0

// Level select field.
`define LEVEL_MSB 3
`define LEVEL_LSB 0
`define LEVEL_RESET 4'he

// Interrupt register fields.
`define BIT_IRQ_REQUEST 0
`define BIT_IRQ_MASK 1
`define IRQ_MASK_RESET 1'b1

// Reset source register field.
`define BIT_RESET_SOURCE 0

// Option byte: default-start-off bit, and its place in memory.
`define OPTION_BYTE_ADDR 20'h000c1
`define BIT_DEFAULT_START_OFF 0

// Control register reset values.
`define ENABLE_RESET 1'b0
`define SOURCE_RESET 1'b0
`define MODE_RESET 1'b0

`endif

// ==== logic/level_sync.v ====
`timescale 1ns/1ns
// Two-stage synchroniser; the first stage feeds only the second.
module level_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

// ==== logic/low_voltage_detect_control.v ====
`timescale 1ns/1ns
`include "low_voltage_detect_consts.vh"
module low_voltage_detect_control #(
  parameter ADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire por_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] option_byte,
  input wire supply_below,
  input wire external_sense_input,
  output wire comp_enable,
  output wire source_select,
  output wire [3:0] level_select,
  output wire detect_reset_req,
  output reg detect_irq,
  output wire irq_pending
);

  localparam ST_LOAD = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg detect_enable_r;
  reg source_select_r;
  reg reset_mode_select_r;
  reg detect_irq_mask_r;
  reg detect_irq_request_flag_r;
  reg default_start_off_r;
  reg prev_below_r;
  reg [3:0] level_select_r;
  reg detect_reset_source_flag_r;
  reg reset_hold_r;
  reg own_reset_r;
  reg [1:0] sysrst_sync_r;
  reg sysrst_prev_r;

  wire [1:0] cmp_sync;
  wire below;
  wire level_flag;
  wire setup;
  wire wr;
  wire hit_control;
  wire hit_level;
  wire hit_irq;
  wire hit_source;
  wire hit_option;
  wire mapped;
  wire sys_released;
  wire crossing;
  wire disable_low;
  wire irq_event;
  wire [7:0] control_rd;

  // Both comparator outputs are synchronised; the mux follows the second stage.
  level_sync #(
    .WIDTH(2),
    .INIT(2'b00)
  ) u_cmp_sync (
    .clk(pclk),
    .rst_n(por_n),
    .d({external_sense_input, supply_below}),
    .q(cmp_sync)
  );

  assign below = source_select_r ? cmp_sync[1] : cmp_sync[0];
  assign level_flag = detect_enable_r & below;

  assign comp_enable = detect_enable_r;
  assign source_select = source_select_r;
  assign level_select = level_select_r;
  assign detect_reset_req = reset_hold_r;
  assign irq_pending = detect_irq_request_flag_r & ~detect_irq_mask_r;

  // APB decode. The slave never inserts wait states.
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign hit_control = (paddr == `OFS_CONTROL);
  assign hit_level = (paddr == `OFS_LEVEL);
  assign hit_irq = (paddr == `OFS_IRQ);
  assign hit_source = (paddr == `OFS_RESET_SOURCE);
  assign hit_option = (paddr == `OFS_OPTION);
  assign mapped = hit_control | hit_level | hit_irq | hit_source | hit_option;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  assign control_rd = {detect_enable_r, 4'h0, source_select_r, reset_mode_select_r, level_flag};

  // Reset request and the state that must outlive a system reset.
  // These flops are cleared only at power-on, except that level_select_r reloads its default after a
  // system reset the detector did not raise; the request they form drives the system reset itself and must not cancel itself.
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      sysrst_sync_r <= 2'b00;
      sysrst_prev_r <= 1'b0;
    end else begin
      sysrst_sync_r <= {sysrst_sync_r[0], presetn};
      sysrst_prev_r <= sysrst_sync_r[1];
    end
  end

  assign sys_released = sysrst_sync_r[1] & ~sysrst_prev_r;

  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      reset_hold_r <= 1'b0;
    end else if (!below) begin
      reset_hold_r <= 1'b0;
    end else if (detect_enable_r & reset_mode_select_r) begin
      reset_hold_r <= 1'b1;
    end
  end

  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      own_reset_r <= 1'b0;
    end else if (reset_hold_r) begin
      own_reset_r <= 1'b1;
    end else if (sys_released) begin
      own_reset_r <= 1'b0;
    end
  end

  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      level_select_r <= `LEVEL_RESET;
    end else if (sys_released & ~own_reset_r) begin
      level_select_r <= `LEVEL_RESET;
    end else if (wr & hit_level & pstrb[0]) begin
      level_select_r <= pwdata[`LEVEL_MSB:`LEVEL_LSB];
    end
  end

  // A detector reset wins over a clear written in the same cycle.
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      detect_reset_source_flag_r <= 1'b0;
    end else if (sys_released & own_reset_r) begin
      detect_reset_source_flag_r <= 1'b1;
    end else if (wr & hit_source & pstrb[0] & pwdata[`BIT_RESET_SOURCE]) begin
      detect_reset_source_flag_r <= 1'b0;
    end
  end

  // Start-up: the option byte is sampled on the first edge after release,
  // never under the asynchronous reset.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_LOAD;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      default_start_off_r <= 1'b1;
    end else if (state_r == ST_LOAD) begin
      default_start_off_r <= option_byte[`BIT_DEFAULT_START_OFF];
    end
  end

  // Control register. Default start forces the detector on even if software
  // had stopped it before the reset; no stabilisation wait is inserted.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_enable_r <= `ENABLE_RESET;
      source_select_r <= `SOURCE_RESET;
      reset_mode_select_r <= `MODE_RESET;
    end else if (state_r == ST_LOAD) begin
      if (!option_byte[`BIT_DEFAULT_START_OFF]) begin
        detect_enable_r <= 1'b1;
        source_select_r <= 1'b0;
        reset_mode_select_r <= 1'b1;
      end
    end else if (wr & hit_control & pstrb[0]) begin
      detect_enable_r <= pwdata[`BIT_ENABLE];
      source_select_r <= pwdata[`BIT_SOURCE];
      reset_mode_select_r <= pwdata[`BIT_MODE];
    end
  end

  // Interrupt events: any crossing seen while enabled in interrupt mode,
  // including one caused by a new level, and a stop while below threshold.
  // A write of the level field with the detector on may cross at once.
  assign crossing = detect_enable_r & ~reset_mode_select_r & (below != prev_below_r);
  assign disable_low = wr & hit_control & pstrb[0] & detect_enable_r & ~pwdata[`BIT_ENABLE] & below;
  assign irq_event = crossing | disable_low;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_below_r <= 1'b0;
      detect_irq <= 1'b0;
    end else begin
      prev_below_r <= below;
      detect_irq <= irq_event;
    end
  end

  // Request flag: the hardware set wins over a software clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_irq_request_flag_r <= 1'b0;
    end else if (irq_event) begin
      detect_irq_request_flag_r <= 1'b1;
    end else if (wr & hit_irq & pstrb[0]) begin
      detect_irq_request_flag_r <= pwdata[`BIT_IRQ_REQUEST];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_irq_mask_r <= `IRQ_MASK_RESET;
    end else if (wr & hit_irq & pstrb[0]) begin
      detect_irq_mask_r <= pwdata[`BIT_IRQ_MASK];
    end
  end

  // Read data is registered in the setup phase so it is stable in access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      if (hit_control) begin
        prdata <= {24'h00_0000, control_rd};
      end else if (hit_level) begin
        prdata <= {28'h000_0000, level_select_r};
      end else if (hit_irq) begin
        prdata <= {30'h0000_0000, detect_irq_mask_r, detect_irq_request_flag_r};
      end else if (hit_source) begin
        prdata <= {31'h0000_0000, detect_reset_source_flag_r};
      end else if (hit_option) begin
        prdata <= {31'h0000_0000, default_start_off_r};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ==== tb/low_voltage_detect_control_checker.sv ====
`timescale 1ns/1ns
`include "low_voltage_detect_consts.vh"
module low_voltage_detect_control_checker #(
  parameter ADDR_W = 8
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] prdata,
  input logic [7:0] option_byte,
  input logic supply_below,
  input logic external_sense_input,
  input logic comp_enable,
  input logic source_select,
  input logic detect_reset_req,
  input logic detect_irq,
  input logic irq_pending
);
  // Only the selected comparator may drive a reset or an interrupt.
  wire sel_below = source_select ? external_sense_input : supply_below;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_ctl;
    psel && penable && !pwrite && paddr == `OFS_CONTROL;
  endsequence
  AST_CTL_BITS: assert property (rd_ctl |-> prdata[`BIT_ENABLE] == comp_enable && prdata[`BIT_SOURCE] == source_select)
    else $error("control read bits differ from outputs");
  AST_FLAG_OFF: assert property (rd_ctl ##0 !comp_enable |-> !prdata[`BIT_LEVEL_FLAG])
    else $error("level flag set while disabled");
  AST_IRQ_EN: assert property (detect_irq |-> $past(comp_enable))
    else $error("interrupt while detector disabled");
  AST_RREQ_EN: assert property ($rose(detect_reset_req) |-> $past(comp_enable))
    else $error("reset request while detector disabled");
  AST_RREQ_SET: assert property ($rose(detect_reset_req) |-> $past(sel_below, 3))
    else $error("reset request without low level");
  AST_RREQ_CLR: assert property ($fell(detect_reset_req) |-> !$past(sel_below, 3))
    else $error("reset request dropped while level low");
  AST_MASK_RST: assert property ($rose(presetn) |-> !irq_pending)
    else $error("interrupt unmasked after reset");
  AST_DFLT: assert property ($rose(presetn) && !option_byte[0] |=> comp_enable && !source_select)
    else $error("default start state missing");
endmodule
bind low_voltage_detect_control low_voltage_detect_control_checker #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .option_byte(option_byte), .supply_below(supply_below), .external_sense_input(external_sense_input),
  .comp_enable(comp_enable), .source_select(source_select), .detect_reset_req(detect_reset_req),
  .detect_irq(detect_irq), .irq_pending(irq_pending));

// ==== tb/low_voltage_detect_control_tb_top.sv ====
`timescale 1ns/1ns
module low_voltage_detect_control_tb_top;
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, er, supply_below, external_sense_input;
  logic comp_enable, source_select, detect_reset_req, detect_irq, irq_pending;
  logic [7:0] paddr, option_byte;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb, level_select;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  low_voltage_detect_control i_low_voltage_detect_control (.pclk(pclk), .presetn(presetn), .por_n(por_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .option_byte(option_byte), .supply_below(supply_below),
    .external_sense_input(external_sense_input), .comp_enable(comp_enable), .source_select(source_select),
    .level_select(level_select), .detect_reset_req(detect_reset_req), .detect_irq(detect_irq),
    .irq_pending(irq_pending));
  always #10 pclk = ~pclk;
  task tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    // Whole run needs well under a thousand cycles.
    if (cyc == 3000) begin
      fails++;
      tally_and_finish;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // The idle cycle keeps two transfers from driving psel in one time step.
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", e, q);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task wait_irq;
    for (int i = 0; i < 20 && detect_irq !== 1'b1; i++) @(posedge pclk);
    chk("irq", 32'h1, detect_irq);
  endtask
  initial begin
    pclk = 0; presetn = 0; por_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hf; option_byte = 8'hfe; supply_below = 0; external_sense_input = 0;
    wt(8);
    presetn <= 1'b1;
    por_n <= 1'b1;
    wt(2);
    rd(8'h00, 32'h82);
    rd(8'h04, 32'he);
    rd(8'h08, 32'h2);
    rd(8'h10, 32'h0);
    wr(8'h04, 32'h3);
    supply_below <= 1'b1;
    wt(5);
    chk("rreq", 32'h1, detect_reset_req);
    presetn <= 1'b0;
    wt(2);
    supply_below <= 1'b0;
    wt(5);
    chk("rreq", 32'h0, detect_reset_req);
    presetn <= 1'b1;
    wt(5);
    chk("level", 32'h3, level_select);
    rd(8'h0c, 32'h1);
    rd(8'h00, 32'h82);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h0);
    wr(8'h00, 32'h80);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    supply_below <= 1'b1;
    wt(6);
    chk("rreq", 32'h0, detect_reset_req);
    rd(8'h00, 32'h0);
    wr(8'h00, 32'h80);
    wt(4);
    wr(8'h08, 32'h2);
    rd(8'h00, 32'h81);
    wr(8'h08, 32'h0);
    chk("pend", 32'h0, irq_pending);
    supply_below <= 1'b0;
    wait_irq;
    chk("pend", 32'h1, irq_pending);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h0);
    supply_below <= 1'b1;
    wt(4);
    wr(8'h00, 32'h80);
    wt(4);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h0);
    wait_irq;
    chk("pend", 32'h1, irq_pending);
    wr(8'h08, 32'h2);
    supply_below <= 1'b0;
    wr(8'h00, 32'h84);
    chk("src", 32'h1, source_select);
    wt(4);
    rd(8'h00, 32'h84);
    wr(8'h00, 32'h86);
    wt(6);
    chk("rreq", 32'h0, detect_reset_req);
    external_sense_input <= 1'b1;
    wt(5);
    chk("rreq", 32'h1, detect_reset_req);
    external_sense_input <= 1'b0;
    wt(5);
    chk("rreq", 32'h0, detect_reset_req);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, er);
    chk("unmapped", 32'h0, q);
    tally_and_finish;
  end
endmodule
